// ==== rtl/smm_pkg.sv ====
/*
 * Constants for the serial monitor mode logic: register map, field positions,
 * reset values, bit-time divisors, link timing and command codes.
 * Assumes a single 100 MHz bus clock that also serves as the monitor bus clock.
 */
package smm_pkg;
  // ****************************************************************
  // Register map (byte addresses), field positions and reset values
  // ****************************************************************
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_SP = 4'h8;
  localparam logic [3:0] OFS_IDX = 4'hC;
  localparam int CFG_IRQ_EN = 0;
  localparam int CFG_RST_EN = 1;
  localparam int CFG_OSC_EN = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  // ****************************************************************
  // Link timing
  // ****************************************************************
  localparam logic [9:0] DIV_EXT = 10'd256;
  localparam logic [9:0] DIV_INT = 10'd335;
  localparam logic [3:0] FRAME_BITS = 4'd10;
  localparam logic [3:0] GAP_BITS = 4'd2;
  localparam logic [3:0] DLY_BITS = 4'd11;
  localparam logic [3:0] SEC_BYTES = 4'd8;
  // ****************************************************************
  // Vector pages and blank byte
  // ****************************************************************
  localparam logic [7:0] PAGE_MON = 8'hFE;
  localparam logic [7:0] PAGE_USER = 8'hFF;
  localparam logic [7:0] BLANK = 8'hFF;
  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] OP_READ = 8'h01;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_INDEXED_READ_CMD = 8'h03;
  localparam logic [7:0] OP_INDEXED_WRITE_CMD = 8'h04;
  localparam logic [7:0] OP_STACK_PTR_READ_CMD = 8'h05;
  localparam logic [7:0] OP_RUN = 8'h06;
  localparam logic [7:0] OP_NONE = 8'h00;
  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    M_USER = 3'b001,
    M_NORMAL = 3'b010,
    M_FORCED = 3'b100
  } smm_mode_type;
  typedef enum logic [5:0] {
    L_OFF = 6'b000001,
    L_RX = 6'b000010,
    L_GAP = 6'b000100,
    L_TX = 6'b001000,
    L_DLY = 6'b010000,
    L_MEM = 6'b100000
  } smm_link_type;
endpackage : smm_pkg

// ==== rtl/smm_monitor.sv ====
/*
 * Serial monitor mode logic: mode entry and latch, pin function routing,
 * watchdog suppression, vector page selection, blank reset vector detection
 * and the single-wire monitor link with its command sequencer.
 * Assumes: sys_rst_in, por_in, vfetch_* and mem_rdata come from logic on clk;
 * pin inputs are asynchronous; an external pullup on the serial wire.
 */
// Summary of operation
// - Mode latched when internal reset releases; mode selects ignored afterwards.
// - Host sends eight security bytes; then device sends ready break.
// - Normal monitor with test voltage: reset and clock on alternate pins.
// - Test voltage dropped: reset and clock pin functions from configuration held at drop.
// - Without test voltage, outside forced mode, interrupt branches sample pin only if enabled.
// - Watchdog off while test voltage present in normal monitor mode.
// - Forced entry ignores both mode select pins.
// - Blank vector entry adds one extra reset cycle after power-on.
// - Two erased vector fetch bytes assert reset and force monitor mode.
// - Forced, interrupt high: inputs except serial pin and clock input.
// - Forced, interrupt low: inputs except serial pin.
// - Monitor mode: interrupt pin never a port input; bit 2 reads zero.
// - Forced: interrupt branches always see the pin enabled.
// - Forced: watchdog always disabled.
// - Forced mode survives every reset except power-on.
// - Monitor uses vector page FE, user mode page FF.
// - NRZ mark/space framing, same rate both directions.
// - Break is ten zero bits.
// - On break, release line two bit times, then send break.
// - Bit time is 256 bus clocks, or 335 on internal oscillator.
// - Six commands: read, write, indexed read/write, stack read, run.
// - Every received byte echoed.
// - Eleven bit delay after command; a break there cancels it.
// - Two bit gap before each echo and before read data.
// - Read data follows echo of final command byte.
module smm_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic test_volt_in,
  input wire logic irq_level_in,
  input wire logic mode_select0_pin,
  input wire logic mode_select1_pin,
  input wire logic serial_comm_in,
  output logic serial_comm_out,
  output logic serial_comm_oe,
  input wire logic sys_rst_in,
  input wire logic por_in,
  input wire logic vfetch_valid,
  input wire logic [7:0] vfetch_data,
  output logic int_reset_r,
  output logic monitor_r,
  output logic forced_r,
  output logic reset_alt_r,
  output logic clock_alt_r,
  output logic pins_input_r,
  output logic irq_branch_en_r,
  output logic porta2_zero_r,
  output logic wdog_dis_r,
  output logic int_osc_r,
  output logic [7:0] vec_page_r,
  output logic [15:0] mem_addr_r,
  output logic [7:0] mem_wdata_r,
  output logic mem_wr_r,
  output logic mem_rd_r,
  input wire logic [7:0] mem_rdata,
  output logic run_user_r
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [4:0] pin_raw;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  assign pin_raw = {serial_comm_in, mode_select1_pin, mode_select0_pin,
                    irq_level_in, test_volt_in};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        sync1_r[i] <= 1'b1;
        sync2_r[i] <= 1'b1;
      end else begin
        sync1_r[i] <= pin_raw[i];
        sync2_r[i] <= sync1_r[i];
      end
    end
  end
  logic hv;
  logic irq_hi;
  logic line;
  assign hv = sync2_r[0];
  assign irq_hi = sync2_r[1];
  assign line = sync2_r[4];

  // ****************************************************************
  // Mode latch and blank vector detection
  // ****************************************************************
  smm_pkg::smm_mode_type mode_r;
  logic sys_rst_d_r;
  logic sticky_r;
  logic [1:0] ff_cnt_r;
  logic [2:0] cfg_r;
  logic [2:0] snap_r;
  logic [15:0] sp_r;
  logic [15:0] idx_r;
  logic sec_done_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= smm_pkg::M_USER;
      sys_rst_d_r <= 1'b1;
      int_osc_r <= 1'b0;
    end else begin
      sys_rst_d_r <= sys_rst_in;
      if (sys_rst_d_r && !sys_rst_in) begin
        int_osc_r <= sticky_r && !irq_hi;
        if (sticky_r) begin
          mode_r <= smm_pkg::M_FORCED;
        end else if (hv && sync2_r[2] && !sync2_r[3]) begin
          mode_r <= smm_pkg::M_NORMAL;
        end else begin
          mode_r <= smm_pkg::M_USER;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sticky_r <= 1'b0;
      ff_cnt_r <= 2'd0;
      int_reset_r <= 1'b0;
    end else begin
      int_reset_r <= 1'b0;
      if (por_in) begin
        sticky_r <= 1'b0;
        ff_cnt_r <= 2'd0;
      end else if (sys_rst_in) begin
        ff_cnt_r <= 2'd0;
      end else if (vfetch_valid && mode_r == smm_pkg::M_USER) begin
        if (vfetch_data != smm_pkg::BLANK) begin
          ff_cnt_r <= 2'd0;
        end else if (ff_cnt_r == 2'd1) begin
          ff_cnt_r <= 2'd0;
          sticky_r <= 1'b1;
          int_reset_r <= 1'b1;
        end else begin
          ff_cnt_r <= 2'd1;
        end
      end
    end
  end

  // ****************************************************************
  // Pin functions, watchdog, vectors
  // ****************************************************************
  logic mon;
  logic nrm_hv;
  assign mon = mode_r != smm_pkg::M_USER;
  assign nrm_hv = mode_r == smm_pkg::M_NORMAL && hv;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap_r <= smm_pkg::CFG_RESET;
    end else if (nrm_hv) begin
      snap_r <= cfg_r;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monitor_r <= 1'b0;
      forced_r <= 1'b0;
      reset_alt_r <= 1'b0;
      clock_alt_r <= 1'b0;
      pins_input_r <= 1'b0;
      irq_branch_en_r <= 1'b0;
      porta2_zero_r <= 1'b0;
      wdog_dis_r <= 1'b0;
      vec_page_r <= smm_pkg::PAGE_USER;
    end else begin
      monitor_r <= mon;
      forced_r <= mode_r == smm_pkg::M_FORCED;
      porta2_zero_r <= mon;
      vec_page_r <= mon ? smm_pkg::PAGE_MON : smm_pkg::PAGE_USER;
      wdog_dis_r <= nrm_hv || mode_r == smm_pkg::M_FORCED;
      pins_input_r <= mode_r == smm_pkg::M_FORCED;
      case (mode_r)
        smm_pkg::M_NORMAL: begin
          reset_alt_r <= hv ? 1'b1 : snap_r[smm_pkg::CFG_RST_EN];
          clock_alt_r <= hv ? 1'b1 : snap_r[smm_pkg::CFG_OSC_EN];
          irq_branch_en_r <= hv || cfg_r[smm_pkg::CFG_IRQ_EN];
        end
        smm_pkg::M_FORCED: begin
          reset_alt_r <= 1'b0;
          clock_alt_r <= !int_osc_r;
          irq_branch_en_r <= 1'b1;
        end
        default: begin
          reset_alt_r <= cfg_r[smm_pkg::CFG_RST_EN];
          clock_alt_r <= cfg_r[smm_pkg::CFG_OSC_EN];
          irq_branch_en_r <= cfg_r[smm_pkg::CFG_IRQ_EN];
        end
      endcase
    end
  end

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  logic acc;
  assign acc = (avs_read || avs_write) && avs_waitrequest;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !acc;
      if (acc && avs_read) begin
        if (avs_address == smm_pkg::OFS_CFG) begin
          avs_readdata <= {29'h0000_0000, cfg_r};
        end else if (avs_address == smm_pkg::OFS_STAT) begin
          avs_readdata <= {24'h0000_00, sec_done_r, int_osc_r, wdog_dis_r, hv,
                           irq_hi, sticky_r, mode_r == smm_pkg::M_FORCED, mon};
        end else if (avs_address == smm_pkg::OFS_SP) begin
          avs_readdata <= {16'h0000, sp_r};
        end else if (avs_address == smm_pkg::OFS_IDX) begin
          avs_readdata <= {16'h0000, idx_r};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= smm_pkg::CFG_RESET;
      sp_r <= smm_pkg::SP_RESET;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == smm_pkg::OFS_CFG) begin
        cfg_r <= avs_writedata[2:0];
      end else if (avs_address == smm_pkg::OFS_SP) begin
        sp_r <= avs_writedata[15:0];
      end
    end
  end

  // ****************************************************************
  // Monitor link and command sequencer
  // ****************************************************************
  smm_pkg::smm_link_type lst_r;
  logic [9:0] blen;
  logic [9:0] tmr_r;
  logic [3:0] bits_r;
  logic tick;
  logic rx_busy_r;
  logic [8:0] rx_sh_r;
  logic [9:0] tx_sh_r;
  logic tx_data_r;
  logic gap_brk_r;
  logic [7:0] tx_byte_r;
  logic [3:0] sec_cnt_r;
  logic [7:0] cmd_r;
  logic [1:0] opn_r;
  logic [15:0] addr_r;
  logic [1:0] left_r;
  logic from_sp_r;
  logic [7:0] rx_byte;
  assign blen = int_osc_r ? smm_pkg::DIV_INT : smm_pkg::DIV_EXT;
  assign tick = tmr_r == 10'd0;
  assign rx_byte = rx_sh_r[8:1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lst_r <= smm_pkg::L_OFF;
      tmr_r <= 10'd0;
      bits_r <= 4'd0;
      rx_busy_r <= 1'b0;
      rx_sh_r <= 9'h000;
      tx_sh_r <= 10'h3FF;
      tx_data_r <= 1'b0;
      gap_brk_r <= 1'b0;
      tx_byte_r <= 8'h00;
      sec_cnt_r <= 4'd0;
      sec_done_r <= 1'b0;
      cmd_r <= smm_pkg::OP_NONE;
      opn_r <= 2'd0;
      addr_r <= 16'h0000;
      idx_r <= 16'h0000;
      left_r <= 2'd0;
      from_sp_r <= 1'b0;
      serial_comm_out <= 1'b0;
      serial_comm_oe <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 8'h00;
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      run_user_r <= 1'b0;
    end else begin
      mem_wr_r <= 1'b0;
      mem_rd_r <= 1'b0;
      run_user_r <= 1'b0;
      tmr_r <= tick ? blen - 10'd1 : tmr_r - 10'd1;
      if (sys_rst_in || !mon) begin
        lst_r <= smm_pkg::L_OFF;
        serial_comm_oe <= 1'b0;
        sec_cnt_r <= 4'd0;
        sec_done_r <= 1'b0;
        cmd_r <= smm_pkg::OP_NONE;
        rx_busy_r <= 1'b0;
      end else begin
        case (lst_r)
          smm_pkg::L_OFF: begin
            lst_r <= smm_pkg::L_RX;
          end
          smm_pkg::L_RX: begin
            if (!rx_busy_r) begin
              if (!line) begin
                rx_busy_r <= 1'b1;
                tmr_r <= {1'b0, blen[9:1]};
                bits_r <= 4'd0;
              end
            end else if (tick && bits_r == 4'd0 && line) begin
              // False start from own break tail in the synchroniser
              rx_busy_r <= 1'b0;
            end else if (tick) begin
              bits_r <= bits_r + 4'd1;
              if (bits_r != 4'd0) begin
                rx_sh_r <= {line, rx_sh_r[8:1]};
              end
              if (bits_r == smm_pkg::FRAME_BITS - 4'd1) begin
                rx_busy_r <= 1'b0;
                lst_r <= smm_pkg::L_GAP;
                bits_r <= smm_pkg::GAP_BITS - 4'd1;
                gap_brk_r <= rx_sh_r[8:1] == 8'h00 && !line;
                tx_byte_r <= rx_sh_r[8:1];
                tx_data_r <= 1'b0;
                if (rx_sh_r[8:1] == 8'h00 && !line) begin
                  cmd_r <= smm_pkg::OP_NONE;
                end
              end
            end
          end
          smm_pkg::L_GAP: begin
            if (tick) begin
              bits_r <= bits_r - 4'd1;
              if (bits_r == 4'd0) begin
                // Line stays released through the gap
                lst_r <= smm_pkg::L_TX;
                bits_r <= smm_pkg::FRAME_BITS - 4'd1;
                tx_sh_r <= gap_brk_r ? 10'h000 : {1'b1, tx_byte_r, 1'b0};
                serial_comm_oe <= 1'b1;
              end
            end
          end
          smm_pkg::L_TX: begin
            if (tick) begin
              bits_r <= bits_r - 4'd1;
              tx_sh_r <= {1'b1, tx_sh_r[9:1]};
              serial_comm_oe <= !tx_sh_r[1];
              if (bits_r == 4'd0) begin
                serial_comm_oe <= 1'b0;
                lst_r <= smm_pkg::L_RX;
                if (tx_data_r) begin
                  if (left_r != 2'd0) begin
                    lst_r <= smm_pkg::L_MEM;
                    mem_rd_r <= !from_sp_r;
                    if (!from_sp_r) begin
                      mem_addr_r <= idx_r;
                      idx_r <= idx_r + 16'd1;
                    end
                  end
                end else if (gap_brk_r) begin
                  gap_brk_r <= 1'b0;
                end else if (!sec_done_r) begin
                  sec_cnt_r <= sec_cnt_r + 4'd1;
                  if (sec_cnt_r == smm_pkg::SEC_BYTES - 4'd1) begin
                    sec_done_r <= 1'b1;
                    gap_brk_r <= 1'b1;
                    lst_r <= smm_pkg::L_TX;
                    bits_r <= smm_pkg::FRAME_BITS - 4'd1;
                    tx_sh_r <= 10'h000;
                    serial_comm_oe <= 1'b1;
                  end
                end else if (cmd_r == smm_pkg::OP_NONE) begin
                  cmd_r <= tx_byte_r;
                  opn_r <= 2'd0;
                  if (tx_byte_r == smm_pkg::OP_READ) begin
                    opn_r <= 2'd2;
                  end else if (tx_byte_r == smm_pkg::OP_WRITE) begin
                    opn_r <= 2'd3;
                  end else if (tx_byte_r == smm_pkg::OP_INDEXED_WRITE_CMD) begin
                    opn_r <= 2'd1;
                  end else if (tx_byte_r == smm_pkg::OP_INDEXED_READ_CMD ||
                               tx_byte_r == smm_pkg::OP_STACK_PTR_READ_CMD ||
                               tx_byte_r == smm_pkg::OP_RUN) begin
                    lst_r <= smm_pkg::L_DLY;
                    bits_r <= smm_pkg::DLY_BITS - 4'd1;
                  end else begin
                    cmd_r <= smm_pkg::OP_NONE;
                  end
                end else begin
                  opn_r <= opn_r - 2'd1;
                  if (opn_r == 2'd1 && (cmd_r == smm_pkg::OP_WRITE ||
                                        cmd_r == smm_pkg::OP_INDEXED_WRITE_CMD)) begin
                    mem_wdata_r <= tx_byte_r;
                  end else begin
                    addr_r <= {addr_r[7:0], tx_byte_r};
                  end
                  if (opn_r == 2'd1) begin
                    lst_r <= smm_pkg::L_DLY;
                    bits_r <= smm_pkg::DLY_BITS - 4'd1;
                  end
                end
              end
            end
          end
          smm_pkg::L_DLY: begin
            if (!line) begin
              cmd_r <= smm_pkg::OP_NONE;
              lst_r <= smm_pkg::L_RX;
              rx_busy_r <= 1'b1;
              tmr_r <= {1'b0, blen[9:1]};
              bits_r <= 4'd0;
            end else if (tick) begin
              bits_r <= bits_r - 4'd1;
              if (bits_r == 4'd0) begin
                cmd_r <= smm_pkg::OP_NONE;
                lst_r <= smm_pkg::L_RX;
                from_sp_r <= 1'b0;
                if (cmd_r == smm_pkg::OP_READ) begin
                  lst_r <= smm_pkg::L_MEM;
                  mem_rd_r <= 1'b1;
                  mem_addr_r <= addr_r;
                  idx_r <= addr_r + 16'd1;
                  left_r <= 2'd1;
                end else if (cmd_r == smm_pkg::OP_INDEXED_READ_CMD) begin
                  lst_r <= smm_pkg::L_MEM;
                  mem_rd_r <= 1'b1;
                  mem_addr_r <= idx_r;
                  idx_r <= idx_r + 16'd1;
                  left_r <= 2'd2;
                end else if (cmd_r == smm_pkg::OP_STACK_PTR_READ_CMD) begin
                  lst_r <= smm_pkg::L_MEM;
                  from_sp_r <= 1'b1;
                  left_r <= 2'd2;
                end else if (cmd_r == smm_pkg::OP_WRITE) begin
                  mem_wr_r <= 1'b1;
                  mem_addr_r <= addr_r;
                  idx_r <= addr_r + 16'd1;
                end else if (cmd_r == smm_pkg::OP_INDEXED_WRITE_CMD) begin
                  mem_wr_r <= 1'b1;
                  mem_addr_r <= idx_r;
                  idx_r <= idx_r + 16'd1;
                end else begin
                  run_user_r <= 1'b1;
                end
              end
            end
          end
          smm_pkg::L_MEM: begin
            left_r <= left_r - 2'd1;
            if (from_sp_r) begin
              tx_byte_r <= left_r == 2'd2 ? sp_r[15:8] : sp_r[7:0];
            end else begin
              tx_byte_r <= mem_rdata;
            end
            tx_data_r <= 1'b1;
            gap_brk_r <= 1'b0;
            lst_r <= smm_pkg::L_GAP;
            bits_r <= smm_pkg::GAP_BITS - 4'd1;
            tmr_r <= blen - 10'd1;
          end
          default: begin
            lst_r <= smm_pkg::L_OFF;
          end
        endcase
      end
    end
  end
endmodule : smm_monitor

// ==== tb/smm_chk.sv ====
/* Checker: port assertions for smm_monitor.
   Assumes it is bound into every smm_monitor instance. */
module smm_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic serial_comm_oe,
  input wire logic vfetch_valid,
  input wire logic [7:0] vfetch_data,
  input wire logic int_reset_r,
  input wire logic monitor_r,
  input wire logic forced_r,
  input wire logic irq_branch_en_r,
  input wire logic porta2_zero_r,
  input wire logic wdog_dis_r,
  input wire logic [7:0] vec_page_r
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************************************************************
  // Sequences and assertions
  // ****************************************************************
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence blank_pair;
    !monitor_r && vfetch_valid && vfetch_data == 8'hFF
      ##1 !monitor_r && vfetch_valid && vfetch_data == 8'hFF;
  endsequence
  a_bus_answer: assert property (bus_req |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_blank_reset: assert property (blank_pair |-> ##[0:4] int_reset_r)
    else $error("no reset on blank vector");
  a_forced_wdog: assert property (forced_r |-> ##[0:2] wdog_dis_r)
    else $error("watchdog on in forced mode");
  a_forced_branch: assert property (forced_r |-> ##[0:2] irq_branch_en_r)
    else $error("branch pin not enabled");
  a_mon_port: assert property (monitor_r |-> ##[0:2] porta2_zero_r)
    else $error("port bit not forced");
  a_mon_vector: assert property (monitor_r |-> ##[0:2] vec_page_r == 8'hFE)
    else $error("wrong vector page");
  a_start_hold: assert property ($rose(serial_comm_oe) |-> serial_comm_oe[*8])
    else $error("start bit too short");
endmodule : smm_chk
bind smm_monitor smm_chk i_smm_chk (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .serial_comm_oe, .vfetch_valid, .vfetch_data, .int_reset_r, .monitor_r, .forced_r,
  .irq_branch_en_r, .porta2_zero_r, .wdog_dis_r, .vec_page_r);

// ==== tb/smm_host.sv ====
/* Host model: far end of the monitor wire, bit time from device mode.
   Assumes wire level = !(device oe | host oe) with a pullup. */
module smm_host (
  input wire logic clk,
  input wire logic line,
  input wire logic int_osc,
  output logic oe = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  int bt;
  assign bt = int_osc ? 335 : 256;
  task automatic put_bit(input logic v, input int k);
    oe <= !v;
    repeat (k * bt) @(posedge clk);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] d);
    put_bit(1'b0, 1);
    for (int i = 0; i < 8; i++) put_bit(d[i], 1);
    put_bit(1'b1, 1);
  endtask : send_byte
  task automatic send_break();
    put_bit(1'b0, 10);
    put_bit(1'b1, 1);
  endtask : send_break
  task automatic get_fall(output int n);
    for (n = 0; line !== 1'b0 && n < 9000; n++) @(posedge clk);
  endtask : get_fall
  task automatic get_byte(output logic [7:0] d, output int gap);
    get_fall(gap);
    repeat (bt / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge clk);
      d[i] = line;
    end
    repeat (bt) @(posedge clk);
  endtask : get_byte
  task automatic get_low(output int n);
    get_fall(n);
    for (n = 0; line === 1'b0 && n < 4000; n++) @(posedge clk);
  endtask : get_low
  task automatic pause(input int k);
    put_bit(1'b1, k + 1);
  endtask : pause
endmodule : smm_host

// ==== tb/serial_monitor_mode_logic_tb_top.sv ====
/* Testbench: forced entry, monitor link traffic and registers of smm_monitor.
   Assumes the host model on the wire and the bound checker. */
module serial_monitor_mode_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, avs_read, avs_write, test_volt_in, irq_level_in, mode_select0_pin;
  logic mode_select1_pin, serial_comm_in, serial_comm_out, serial_comm_oe, host_oe, sys_rst_in;
  logic por_in, vfetch_valid, avs_waitrequest, int_reset_r, monitor_r, forced_r, reset_alt_r;
  logic clock_alt_r, pins_input_r, irq_branch_en_r, porta2_zero_r, wdog_dis_r, int_osc_r;
  logic mem_wr_r, mem_rd_r, run_user_r;
  logic [3:0] avs_address;
  logic [7:0] vfetch_data, vec_page_r, mem_wdata_r, mem_rdata, b;
  logic [15:0] mem_addr_r, rd_addr;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int failures, total_checks, gap, low, runs, bt;
  assign serial_comm_in = !(serial_comm_oe || host_oe);
  assign mem_rdata = mem_addr_r[7:0] ^ 8'hA5;
  assign bt = i_smm_host.bt;
  smm_monitor i_smm_monitor (.*);
  smm_host i_smm_host (.clk, .line(serial_comm_in), .int_osc(int_osc_r), .oe(host_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) begin
    if (mem_rd_r === 1'b1) rd_addr <= mem_addr_r;
    if (run_user_r === 1'b1) runs++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic sysrst(input logic p);
    sys_rst_in <= 1'b1;
    por_in <= p;
    repeat (4) @(posedge clk);
    sys_rst_in <= 1'b0;
    por_in <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : sysrst
  task automatic xfer(input logic [7:0] d);
    i_smm_host.pause(1);
    i_smm_host.send_byte(d);
    i_smm_host.get_byte(b, gap);
    check(b, d);
    check(gap >= bt * 3 / 2 && gap <= bt * 3 / 2 + 12, 1'h1);
  endtask : xfer
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h8, 32'h1234);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, 32'h1234);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
  endtask : t_regs
  task automatic t_forced();
    vfetch_valid <= 1'b1;
    vfetch_data <= 8'hFF;
    repeat (2) @(posedge clk);
    vfetch_valid <= 1'b0;
    for (int n = 0; int_reset_r !== 1'b1 && n < 8; n++) @(posedge clk);
    check(int_reset_r, 1'h1);
    sysrst(1'b0);
    check({forced_r, monitor_r, wdog_dis_r, irq_branch_en_r}, 4'hF);
    check({porta2_zero_r, pins_input_r, clock_alt_r, vec_page_r}, 11'h7FE);
    check({reset_alt_r, int_osc_r, serial_comm_out}, 3'h0);
    bus(1'b0, 4'h4, 32'h0);
    check(rd[1:0], 2'h3);
  endtask : t_forced
  task automatic t_secure();
    for (int i = 0; i < 8; i++) xfer(8'(i));
    i_smm_host.get_low(low);
    check(low >= 10 * bt - 1 && low <= 10 * bt + 1, 1'h1);
  endtask : t_secure
  task automatic t_read();
    xfer(smm_pkg::OP_READ);
    xfer(8'h12);
    xfer(8'h34);
    i_smm_host.get_byte(b, gap);
    check(gap >= 12 * bt, 1'h1);
    check(b, 8'h91);
    check(rd_addr, 16'h1234);
  endtask : t_read
  task automatic t_cancel();
    xfer(smm_pkg::OP_RUN);
    i_smm_host.pause(2);
    i_smm_host.send_break();
    i_smm_host.get_low(low);
    check(low >= 10 * bt - 1 && low <= 10 * bt + 1, 1'h1);
    check(32'(runs), 32'h0);
  endtask : t_cancel
  task automatic t_resets();
    sysrst(1'b0);
    check(forced_r, 1'h1);
    sysrst(1'b1);
    check({monitor_r, forced_r, vec_page_r}, 10'h0FF);
  endtask : t_resets
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    {rst, sys_rst_in, por_in, irq_level_in, mode_select0_pin, mode_select1_pin} = 6'h3F;
    {avs_read, avs_write, test_volt_in, vfetch_valid, avs_address} = 8'h0;
    {avs_writedata, vfetch_data} = 40'h0;
    runs = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    sysrst(1'b1);
    t_regs();
    t_forced();
    t_secure();
    t_read();
    t_cancel();
    t_resets();
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule : serial_monitor_mode_logic_tb_top
